// ===== core/qepc_counter_top.sv
`timescale 1ns/1ps
// Contract
// - four blocks, event and pulse-width counters
// - zero-or-capture rising edge clears or captures
// - clock/direction: clock edge steps, direction sets way
// - four-edge: every edge counts, order sets way
// - each counting input may be inverted
// - pulse-width counter runs on reference clock
// - pulse-width value captured on selected input edge
// - software command captures counter values
// - commands act through per-counter masks
// - enable write sets every counter's run state
// - counters wrap modulo two to thirty-two
// - no overflow or lap flag kept
// - clock/direction counts up to maximum rate
// - zero-or-capture zeroes or fills primary capture
// - mode bit 0 selects counting scheme
// - mode bit 1 selects clear behaviour
// - mode bits 2,3 invert counting inputs
// - mode bit 4 selects clear or capture
// - mode bit 5 enables zero-or-capture input
// - per-counter single-ended or differential select
// - combined read captures then returns; status read
// - four-edge gives four counts per cycle
// - mode bit 6 edge polarity, bits 7,8 source
// - rise captures newest, reference edge shifts history
module qepc_counter_top #(
  parameter int COUNTERS = qepc_pkg::COUNTERS,
  parameter int WIDTH    = qepc_pkg::COUNT_WIDTH
) (
  input  wire logic                        ref_clk,
  input  wire logic                        reset,
  input  wire logic                        pwRefClk,
  input  wire logic [COUNTERS-1:0]         inputA,
  input  wire logic [COUNTERS-1:0]         inputB,
  input  wire logic [COUNTERS-1:0]         zeroOrCaptureInput,
  input  wire logic                        modeWrite,
  input  wire logic [$clog2(COUNTERS)-1:0] modeIndex,
  input  wire logic [qepc_pkg::MODE_WIDTH-1:0] modeData,
  input  wire logic                        enableWrite,
  input  wire logic [COUNTERS-1:0]         enableMask,
  input  wire logic                        clearStrobe,
  input  wire logic                        captureStrobe,
  input  wire logic                        pulseWidthCaptureCommand,
  input  wire logic [COUNTERS-1:0]         commandMask,
  input  wire logic                        signallingWrite,
  input  wire logic [COUNTERS-1:0]         signallingMask,
  input  wire logic                        readStrobe,
  input  qepc_pkg::qepc_read_type          readCmd,
  input  wire logic [$clog2(COUNTERS)-1:0] readIndex,
  output logic      [WIDTH-1:0]            readData,
  output logic                             readValid,
  output logic      [COUNTERS-1:0]         running,
  output logic      [COUNTERS-1:0]         inputSignallingSelect,
  output logic      [COUNTERS*WIDTH-1:0]   eventCount,
  output logic      [COUNTERS*WIDTH-1:0]   eventCapture,
  output logic      [COUNTERS*WIDTH-1:0]   pwCount,
  output logic      [COUNTERS*WIDTH-1:0]   newestRiseCapture,
  output logic      [COUNTERS*WIDTH-1:0]   secondRiseCapture,
  output logic      [COUNTERS*WIDTH-1:0]   thirdRiseCapture,
  output logic      [COUNTERS*WIDTH-1:0]   newestFallCapture,
  output logic      [COUNTERS*WIDTH-1:0]   secondFallCapture,
  output logic      [COUNTERS*WIDTH-1:0]   thirdFallCapture,
  output logic      [COUNTERS*WIDTH-1:0]   pwSoftCapture
);

  //////////////////////////////////////////////////////////////////////////

  logic [3*COUNTERS-1:0] pinsSynced;
  logic [COUNTERS-1:0]   aSync;
  logic [COUNTERS-1:0]   bSync;
  logic [COUNTERS-1:0]   zSync;
  logic [WIDTH-1:0]      statusWord;

  // pins cross into ref_clk through two flops
  qepc_sync #(.WIDTH(3*COUNTERS)) pinSync (
    .clk    (ref_clk),
    .async  ({zeroOrCaptureInput, inputB, inputA}),
    .synced (pinsSynced)
  );

  // pin groups after the synchroniser
  assign aSync = pinsSynced[COUNTERS-1:0];
  assign bSync = pinsSynced[2*COUNTERS-1:COUNTERS];
  assign zSync = pinsSynced[3*COUNTERS-1:2*COUNTERS];

  //////////////////////////////////////////////////////////////////////////

  // run state: one write replaces every counter's bit at once
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      running <= qepc_pkg::MASK_RESET;
    else if (enableWrite)
      running <= enableMask;
  end

  // receiver selection per counter, 0 single-ended
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      inputSignallingSelect <= qepc_pkg::MASK_RESET;
    else if (signallingWrite)
      inputSignallingSelect <= signallingMask;
  end

  //////////////////////////////////////////////////////////////////////////

  // status: run bits low, synchronised zero-or-capture levels above
  assign statusWord = WIDTH'({zSync, running});

  // read port: answer one cycle after the strobe
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      readValid <= 1'b0;
    else
      readValid <= readStrobe;
  end

  // read data mux; a count read returns the value it also captures
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      readData <= qepc_pkg::COUNT_RESET;
    else if (readStrobe)
    begin
      case (readCmd)
        qepc_pkg::QEPC_READ_COUNT:
          readData <= eventCount[readIndex*WIDTH +: WIDTH];
        qepc_pkg::QEPC_READ_CAPTURE:
          readData <= eventCapture[readIndex*WIDTH +: WIDTH];
        qepc_pkg::QEPC_READ_STATUS:
          readData <= statusWord;
        default:
          readData <= qepc_pkg::COUNT_RESET;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////

  // one event counter and one pulse-width counter per block
  for (genvar i = 0; i < COUNTERS; i++)
  begin : gBlock
    logic [qepc_pkg::MODE_WIDTH-1:0] mode;
    logic [WIDTH-1:0]                count;
    logic [WIDTH-1:0]                capture;
    logic                            aNow;
    logic                            bNow;
    logic                            aPrev;
    logic                            bPrev;
    logic                            zPrev;
    logic                            step;
    logic                            up;
    logic                            zRise;
    logic                            zeroCountFunction;
    logic                            captureByInput;
    logic                            readHit;
    logic                            clearToggle;
    logic                            captureToggle;

    // mode register, written by index
    always_ff @(posedge ref_clk)
    begin
      if (reset)
        mode <= qepc_pkg::MODE_RESET;
      else if (modeWrite && (modeIndex == i))
        mode <= modeData;
    end

    // inversion moves both the active edge and the direction
    assign aNow = aSync[i] ^ mode[qepc_pkg::MODE_INVERT_A];
    assign bNow = bSync[i] ^ mode[qepc_pkg::MODE_INVERT_B];

    // previous input levels for edge detection
    always_ff @(posedge ref_clk)
    begin
      if (reset)
      begin
        aPrev <= 1'b0;
        bPrev <= 1'b0;
        zPrev <= 1'b0;
      end
      else
      begin
        aPrev <= aNow;
        bPrev <= bNow;
        zPrev <= zSync[i];
      end
    end

    // counting scheme decode
    always_comb
    begin
      if (mode[qepc_pkg::MODE_QUAD])
      begin
        // exactly one input moved; both at once is an illegal jump
        step = (aNow ^ aPrev) ^ (bNow ^ bPrev);
        up = aNow ^ bPrev;
      end
      else
      begin
        step = aNow & ~aPrev;
        up = bNow;
      end
    end

    // zero-or-capture input decode
    assign zRise = zSync[i] & ~zPrev;
    assign zeroCountFunction = mode[qepc_pkg::MODE_ZC_ENABLE]
      & ~mode[qepc_pkg::MODE_ROLE_CAPT]
      & (mode[qepc_pkg::MODE_LEVEL_CLEAR] ? zSync[i] : zRise);
    assign captureByInput = mode[qepc_pkg::MODE_ZC_ENABLE]
      & mode[qepc_pkg::MODE_ROLE_CAPT] & zRise;
    assign readHit = readStrobe
      && (readCmd == qepc_pkg::QEPC_READ_COUNT) && (readIndex == i);

    // event count: clear wins over a step in the same cycle
    always_ff @(posedge ref_clk)
    begin
      if (reset)
        count <= qepc_pkg::COUNT_RESET;
      else if ((clearStrobe && commandMask[i]) || zeroCountFunction)
        count <= qepc_pkg::COUNT_RESET;
      else if (running[i] && step)
        count <= up ? count + 1'b1 : count - 1'b1;
    end

    // primary capture register
    always_ff @(posedge ref_clk)
    begin
      if (reset)
        capture <= qepc_pkg::COUNT_RESET;
      else if ((captureStrobe && commandMask[i]) || readHit
               || captureByInput)
        capture <= count;
    end

    // commands for the reference domain travel as toggles
    always_ff @(posedge ref_clk)
    begin
      if (reset)
      begin
        clearToggle <= 1'b0;
        captureToggle <= 1'b0;
      end
      else
      begin
        if (clearStrobe && commandMask[i])
          clearToggle <= ~clearToggle;
        if (pulseWidthCaptureCommand && commandMask[i])
          captureToggle <= ~captureToggle;
      end
    end

    assign eventCount[i*WIDTH +: WIDTH] = count;
    assign eventCapture[i*WIDTH +: WIDTH] = capture;

    // pulse-width counter on the reference clock
    qepc_pw_counter #(.WIDTH(WIDTH)) pwUnit (
      .pwRefClk           (pwRefClk),
      .resetLevel         (reset),
      .run                (running[i]),
      .refRising          (mode[qepc_pkg::MODE_PW_RISING]),
      .selectA            (mode[qepc_pkg::MODE_PW_SELECT_A]),
      .selectZero         (mode[qepc_pkg::MODE_PW_SELECT_Z]),
      .clearToggle        (clearToggle),
      .captureToggle      (captureToggle),
      .inputA             (inputA[i]),
      .inputB             (inputB[i]),
      .zeroOrCaptureInput (zeroOrCaptureInput[i]),
      .pwCount            (pwCount[i*WIDTH +: WIDTH]),
      .newestRiseCapture  (newestRiseCapture[i*WIDTH +: WIDTH]),
      .secondRiseCapture  (secondRiseCapture[i*WIDTH +: WIDTH]),
      .thirdRiseCapture   (thirdRiseCapture[i*WIDTH +: WIDTH]),
      .newestFallCapture  (newestFallCapture[i*WIDTH +: WIDTH]),
      .secondFallCapture  (secondFallCapture[i*WIDTH +: WIDTH]),
      .thirdFallCapture   (thirdFallCapture[i*WIDTH +: WIDTH]),
      .softCapture        (pwSoftCapture[i*WIDTH +: WIDTH])
    );
  end

endmodule

// ===== core/qepc_pkg.sv
package qepc_pkg;

  // block geometry
  localparam int COUNTERS    = 4;
  localparam int COUNT_WIDTH = 32;
  localparam int MODE_WIDTH  = 9;

  // mode register bit positions
  localparam int MODE_QUAD        = 0; // 0 clock/direction, 1 four-edge
  localparam int MODE_LEVEL_CLEAR = 1; // 0 clear on rising edge of input
  localparam int MODE_INVERT_A    = 2;
  localparam int MODE_INVERT_B    = 3;
  localparam int MODE_ROLE_CAPT   = 4; // 0 zero count, 1 capture count
  localparam int MODE_ZC_ENABLE   = 5;
  localparam int MODE_PW_RISING   = 6; // 1 rising edge is reference
  localparam int MODE_PW_SELECT_A = 7; // 0 input B, 1 input A
  localparam int MODE_PW_SELECT_Z = 8; // 1 zero-or-capture input

  // reset values
  localparam logic [MODE_WIDTH-1:0]  MODE_RESET  = 9'h000;
  localparam logic [COUNT_WIDTH-1:0] COUNT_RESET = 32'h0000_0000;
  localparam logic [COUNTERS-1:0]    MASK_RESET  = 4'h0;

  // timing
  localparam longint REF_CLK_HZ         = 40_000_000;
  localparam longint PW_REF_HZ          = 100_000_000;
  localparam longint MAX_COUNT_RATE_HZ  = 20_000_000;
  localparam int     QUAD_EDGES         = 4;
  localparam longint MAX_QUAD_INPUT_HZ  = MAX_COUNT_RATE_HZ / QUAD_EDGES;
  // least spacing of counted edges, in ref_clk cycles, rounded up
  localparam int MIN_EDGE_CYCLES =
    int'((REF_CLK_HZ + MAX_COUNT_RATE_HZ - 1) / MAX_COUNT_RATE_HZ);

  // read commands
  typedef enum logic [1:0]
  {
    QEPC_READ_COUNT,
    QEPC_READ_CAPTURE,
    QEPC_READ_STATUS
  } qepc_read_type;

endpackage

// ===== core/qepc_sync.sv
`timescale 1ns/1ps
// two-flop synchroniser, no reset so it can carry a reset level too
module qepc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic [WIDTH-1:0] async,
  output logic      [WIDTH-1:0] synced
);

  logic [WIDTH-1:0] stage1;

  // first stage feeds only the second
  always_ff @(posedge clk)
  begin
    stage1 <= async;
    synced <= stage1;
  end

endmodule

// ===== core/qepc_pw_counter.sv
`timescale 1ns/1ps
// pulse-width counter of one block, runs on the reference clock
module qepc_pw_counter #(
  parameter int WIDTH = qepc_pkg::COUNT_WIDTH
) (
  input  wire logic             pwRefClk,
  input  wire logic             resetLevel,
  input  wire logic             run,
  input  wire logic             refRising,
  input  wire logic             selectA,
  input  wire logic             selectZero,
  input  wire logic             clearToggle,
  input  wire logic             captureToggle,
  input  wire logic             inputA,
  input  wire logic             inputB,
  input  wire logic             zeroOrCaptureInput,
  output logic      [WIDTH-1:0] pwCount,
  output logic      [WIDTH-1:0] newestRiseCapture,
  output logic      [WIDTH-1:0] secondRiseCapture,
  output logic      [WIDTH-1:0] thirdRiseCapture,
  output logic      [WIDTH-1:0] newestFallCapture,
  output logic      [WIDTH-1:0] secondFallCapture,
  output logic      [WIDTH-1:0] thirdFallCapture,
  output logic      [WIDTH-1:0] softCapture
);

  logic [9:0] synced;
  logic       pwSignal;
  logic       signalPrev;
  logic       clearSeen;
  logic       captureSeen;
  logic       rise;
  logic       fall;
  logic       shiftHistory;
  logic       clearEvent;
  logic       captureEvent;

  // every control and pin enters this domain through two flops
  qepc_sync #(.WIDTH(10)) crossIn (
    .clk    (pwRefClk),
    .async  ({zeroOrCaptureInput, inputB, inputA, captureToggle,
              clearToggle, selectZero, selectA, refRising, run,
              resetLevel}),
    .synced (synced)
  );

  // source select and edge decode
  assign pwSignal = synced[4] ? synced[9] : (synced[3] ? synced[7]
                                                       : synced[8]);
  assign rise = pwSignal & ~signalPrev;
  assign fall = ~pwSignal & signalPrev;
  assign shiftHistory = synced[2] ? rise : fall;
  assign clearEvent = synced[5] ^ clearSeen;
  assign captureEvent = synced[6] ^ captureSeen;

  // edge and toggle history
  always_ff @(posedge pwRefClk)
  begin
    if (synced[0])
    begin
      signalPrev <= 1'b0;
      clearSeen <= 1'b0;
      captureSeen <= 1'b0;
    end
    else
    begin
      signalPrev <= pwSignal;
      clearSeen <= synced[5];
      captureSeen <= synced[6];
    end
  end

  // count of reference periods while run is set, wraps
  always_ff @(posedge pwRefClk)
  begin
    if (synced[0] || clearEvent)
      pwCount <= qepc_pkg::COUNT_RESET;
    else if (synced[1])
      pwCount <= pwCount + 1'b1;
  end

  // edge captures with three-deep history for both polarities
  always_ff @(posedge pwRefClk)
  begin
    if (synced[0])
    begin
      newestRiseCapture <= qepc_pkg::COUNT_RESET;
      secondRiseCapture <= qepc_pkg::COUNT_RESET;
      thirdRiseCapture <= qepc_pkg::COUNT_RESET;
      newestFallCapture <= qepc_pkg::COUNT_RESET;
      secondFallCapture <= qepc_pkg::COUNT_RESET;
      thirdFallCapture <= qepc_pkg::COUNT_RESET;
    end
    else
    begin
      if (rise)
        newestRiseCapture <= pwCount;
      if (fall)
        newestFallCapture <= pwCount;
      if (shiftHistory)
      begin
        thirdRiseCapture <= secondRiseCapture;
        thirdFallCapture <= secondFallCapture;
        secondRiseCapture <= rise ? pwCount : newestRiseCapture;
        secondFallCapture <= fall ? pwCount : newestFallCapture;
      end
    end
  end

  // software capture
  always_ff @(posedge pwRefClk)
  begin
    if (synced[0])
      softCapture <= qepc_pkg::COUNT_RESET;
    else if (captureEvent)
      softCapture <= pwCount;
  end

endmodule

// ===== testbench/qepc_counter_monitor.sv
`timescale 1ns/1ps
// watches the counter block at its ports
module qepc_counter_monitor #(
  parameter int COUNTERS = 4,
  parameter int WIDTH    = 32
) (
  input wire logic                        ref_clk,
  input wire logic                        reset,
  input wire logic                        pwRefClk,
  input wire logic                        enableWrite,
  input wire logic [COUNTERS-1:0]         enableMask,
  input wire logic                        clearStrobe,
  input wire logic [COUNTERS-1:0]         commandMask,
  input wire logic                        readStrobe,
  input qepc_pkg::qepc_read_type          readCmd,
  input wire logic [$clog2(COUNTERS)-1:0] readIndex,
  input wire logic [WIDTH-1:0]            readData,
  input wire logic                        readValid,
  input wire logic [COUNTERS-1:0]         running,
  input wire logic [COUNTERS*WIDTH-1:0]   eventCount,
  input wire logic [COUNTERS*WIDTH-1:0]   eventCapture,
  input wire logic [COUNTERS*WIDTH-1:0]   pwCount
);
  logic [$clog2(COUNTERS)-1:0] lastIndex;
  logic [WIDTH-1:0]            countAtRead;
  wire logic [WIDTH-1:0]       count0 = eventCount[WIDTH-1:0];
  wire logic [WIDTH-1:0]       pw0    = pwCount[WIDTH-1:0];

  // remembers the read index and that counter's count from the previous cycle
  always_ff @(posedge ref_clk)
  begin
    lastIndex   <= readIndex;
    countAtRead <= eventCount[readIndex*WIDTH +: WIDTH];
  end

  sequence s_count_read;
    readStrobe && readCmd == qepc_pkg::QEPC_READ_COUNT;
  endsequence
  sequence s_status_read;
    readStrobe && readCmd == qepc_pkg::QEPC_READ_STATUS;
  endsequence

  //////////////////////////////////////////////////////////////////////////
  a_enable_sets_run: assert property (@(posedge ref_clk)
    disable iff (reset) enableWrite |=> running == $past(enableMask))
    else $error("run state differs from enable mask");
  a_clear_zeroes_count: assert property (@(posedge ref_clk)
    disable iff (reset) clearStrobe && commandMask[0] |=> count0 == '0)
    else $error("masked clear left a count");
  a_count_read_captures: assert property (@(posedge ref_clk)
    disable iff (reset) s_count_read |=> readValid && readData == countAtRead
    && eventCapture[lastIndex*WIDTH +: WIDTH] == countAtRead)
    else $error("count read did not capture and return the count");
  a_status_read_layout: assert property (@(posedge ref_clk)
    disable iff (reset) s_status_read |=> readValid
    && readData[3:0] == $past(running) && readData[WIDTH-1:8] == '0)
    else $error("status word wrong");
  a_valid_only_answer: assert property (@(posedge ref_clk)
    disable iff (reset) !readStrobe |=> !readValid)
    else $error("read answer without request");
  a_count_step_one: assert property (@(posedge ref_clk)
    disable iff (reset) $changed(count0) |-> count0 == '0
    || (count0 - $past(count0)) inside {32'h0000_0001, 32'hFFFF_FFFF})
    else $error("event count moved by more than one");
  a_reset_clears_all: assert property (@(posedge ref_clk)
    reset |=> running == '0 && eventCount == '0 && !readValid)
    else $error("reset left state behind");
  a_pw_advances_one: assert property (@(posedge pwRefClk)
    disable iff (reset) $changed(pw0) |-> pw0 == '0
    || pw0 - $past(pw0) == 32'h0000_0001)
    else $error("pulse-width count jumped");
endmodule

bind qepc_counter_top qepc_counter_monitor #(.COUNTERS(COUNTERS),
  .WIDTH(WIDTH)) i_monitor (.ref_clk, .reset, .pwRefClk, .enableWrite,
  .enableMask, .clearStrobe, .commandMask, .readStrobe, .readCmd,
  .readIndex, .readData, .readValid, .running, .eventCount,
  .eventCapture, .pwCount);

// ===== testbench/qepc_encoder_model.sv
`timescale 1ns/1ps
// quadrature encoder or clock/direction source on the counting inputs
module qepc_encoder_model (
  input  wire logic       ref_clk,
  input  wire logic       stepReq,
  input  wire logic       stepUp,
  input  wire logic       quadMode,
  input  wire logic [3:0] holdCycles,
  output logic            lineA = 1'h0,
  output logic            lineB = 1'h0,
  output logic            busy
);
  logic [1:0] phase = 2'h0;
  logic [1:0] stage = 2'h0;
  logic [3:0] hold  = 4'h0;
  logic [1:0] nextPhase;

  assign nextPhase = stepUp ? phase + 2'h1 : phase - 2'h1;
  assign busy      = stage != 2'h0;

  // every line level stands holdCycles+1 cycles, so the rate stays legal
  always @(posedge ref_clk)
  begin
    if (stage == 2'h0)
    begin
      if (stepReq)
      begin
        hold <= holdCycles;
        if (quadMode)
        begin
          phase <= nextPhase;
          lineA <= nextPhase[1] ^ nextPhase[0];
          lineB <= nextPhase[1];
          stage <= 2'h3;
        end
        else
        begin
          phase <= {stepUp, stepUp};
          lineB <= stepUp;
          stage <= 2'h1;
        end
      end
    end
    else if (hold != 4'h0)
      hold <= hold - 4'h1;
    else
    begin
      hold  <= holdCycles;
      stage <= stage + 2'h1;
      if (stage == 2'h1)
        lineA <= 1'h1;
      else if (stage == 2'h2)
        lineA <= 1'h0;
    end
  end
endmodule

// ===== testbench/qepc_counter_tb_top.sv
`timescale 1ns/1ps
module qepc_counter_tb_top;
  typedef struct {
    logic [8:0]  mode;
    logic        up;
    int          steps;
    logic [31:0] want;
  } qepc_row_type;

  localparam logic [5:0] MODE = 6'h20;
  localparam logic [5:0] EN   = 6'h10;
  localparam logic [5:0] ZERO = 6'h08;
  localparam logic [5:0] CAP  = 6'h04;
  localparam logic [5:0] PWC  = 6'h02;
  localparam logic [5:0] SIG  = 6'h01;

  logic                    ref_clk = 1'h0;
  logic                    pwRefClk = 1'h0;
  logic                    reset = 1'h1;
  logic [5:0]              strb = 6'h00;
  logic [8:0]              modeData = 9'h000;
  logic [3:0]              mask = 4'h0;
  logic [3:0]              zeroOrCaptureInput = 4'h0;
  logic                    readStrobe = 1'h0;
  qepc_pkg::qepc_read_type readCmd = qepc_pkg::QEPC_READ_COUNT;
  logic                    stepReq = 1'h0;
  logic                    stepUp = 1'h0;
  logic                    quadMode = 1'h0;
  logic [3:0]              holdCycles = 4'h2;
  logic                    lineA;
  logic                    lineB;
  logic                    busy;
  wire logic [3:0]         inputA = {4{lineA}};
  wire logic [3:0]         inputB = {4{lineB}};
  logic [31:0]             readData;
  logic                    readValid;
  logic [3:0]              running;
  logic [3:0]              inputSignallingSelect;
  logic [127:0]            eventCount;
  logic [127:0]            eventCapture;
  logic [127:0]            pwCount;
  logic [127:0]            newestRiseCapture;
  logic [127:0]            thirdRiseCapture;
  logic [127:0]            newestFallCapture;
  logic [127:0]            pwSoftCapture;
  int                      num_errors = 0;
  int                      checks_done = 0;
  qepc_row_type            rows [6] = '{
    '{9'h000, 1'h1, 3, 32'h0000_0003}, '{9'h000, 1'h0, 2, 32'hFFFF_FFFE},
    '{9'h001, 1'h1, 4, 32'h0000_0004}, '{9'h001, 1'h0, 4, 32'hFFFF_FFFC},
    '{9'h008, 1'h1, 3, 32'hFFFF_FFFD}, '{9'h005, 1'h1, 4, 32'hFFFF_FFFC}};

  qepc_counter_top i_dut (
    .ref_clk, .reset, .pwRefClk, .inputA, .inputB, .zeroOrCaptureInput,
    .modeWrite(strb[5]), .modeIndex(2'h0), .modeData,
    .enableWrite(strb[4]), .enableMask(mask), .clearStrobe(strb[3]),
    .captureStrobe(strb[2]), .pulseWidthCaptureCommand(strb[1]),
    .commandMask(mask), .signallingWrite(strb[0]), .signallingMask(mask),
    .readStrobe, .readCmd, .readIndex(2'h0), .readData, .readValid,
    .running, .inputSignallingSelect, .eventCount, .eventCapture, .pwCount,
    .newestRiseCapture, .secondRiseCapture(), .thirdRiseCapture,
    .newestFallCapture, .secondFallCapture(), .thirdFallCapture(),
    .pwSoftCapture);

  qepc_encoder_model i_source (.ref_clk, .stepReq, .stepUp, .quadMode,
    .holdCycles, .lineA, .lineB, .busy);

  // system clock and the unrelated pulse-width reference clock
  initial
    forever #12.5 ref_clk = ~ref_clk;
  initial
  begin
    #7;
    forever #24 pwRefClk = ~pwRefClk;
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d, errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] want);
    checks_done++;
    if (got !== want)
    begin
      num_errors++;
      $display("Error at %0t: got %h, expected %h", $time, got, want);
    end
  endtask

  // one-cycle control strobe with its mode word and counter mask
  task automatic drive(input logic [5:0] which, input logic [8:0] mode,
                       input logic [3:0] bits);
    @(posedge ref_clk);
    strb     <= which;
    modeData <= mode;
    mask     <= bits;
    @(posedge ref_clk);
    strb <= 6'h00;
    #1;
  endtask

  task automatic read(input qepc_pkg::qepc_read_type cmd,
                      output logic [31:0] d);
    @(posedge ref_clk);
    readStrobe <= 1'h1;
    readCmd    <= cmd;
    @(posedge ref_clk);
    readStrobe <= 1'h0;
    #1;
    check({31'h0, readValid}, 32'h0000_0001);
    d = readData;
  endtask

  // asks the source for n steps, each waited for under a bound
  task automatic steps(input int n, input logic up, input logic quad,
                       input logic [3:0] hold);
    int k;
    for (int i = 0; i < n; i++)
    begin
      @(posedge ref_clk);
      stepReq    <= 1'h1;
      stepUp     <= up;
      quadMode   <= quad;
      holdCycles <= hold;
      @(posedge ref_clk);
      stepReq <= 1'h0;
      #1;
      for (k = 0; busy && k < 100; k++)
        @(posedge ref_clk) #1;
      if (busy)
      begin
        num_errors++;
        $display("Error at %0t: source never went idle", $time);
        results();
      end
    end
    repeat (4) @(posedge ref_clk);
    #1;
  endtask

  task automatic zc_rise();
    @(posedge ref_clk) zeroOrCaptureInput <= 4'h1;
    repeat (4) @(posedge ref_clk);
    #1;
  endtask

  // main sequence: reset, table of counting modes, then the odd cases
  initial
  begin
    logic [31:0] d;
    logic [31:0] t;
    repeat (20) @(posedge ref_clk);
    reset <= 1'h0;
    #1;
    check({28'h0, running}, 32'h0000_0000);
    check(eventCount[127:96], 32'h0000_0000);
    check(eventCapture[31:0], 32'h0000_0000);
    drive(EN, 9'h000, 4'h3);
    check({28'h0, running}, 32'h0000_0003);
    drive(EN, 9'h000, 4'h2);
    check({28'h0, running}, 32'h0000_0002);
    drive(SIG, 9'h000, 4'hF);
    check({28'h0, inputSignallingSelect}, 32'h0000_000F);
    drive(SIG, 9'h000, 4'h0);
    check({28'h0, inputSignallingSelect}, 32'h0000_0000);
    foreach (rows[i])
    begin
      drive(EN, 9'h000, 4'h0);
      drive(MODE, rows[i].mode, 4'h0);
      drive(ZERO, 9'h000, 4'h1);
      drive(EN, 9'h000, (i == 0) ? 4'hF : 4'h1);
      steps(rows[i].steps, rows[i].up, rows[i].mode[0], 4'h2);
      read(qepc_pkg::QEPC_READ_COUNT, d);
      check(d, rows[i].want);
    end
    drive(CAP, 9'h000, 4'h2);
    check(eventCapture[63:32], 32'h0000_0003);
    check(eventCapture[95:64], 32'h0000_0000);
    read(qepc_pkg::QEPC_READ_STATUS, d);
    check(d, 32'h0000_0001);
    drive(EN, 9'h000, 4'h0);
    drive(MODE, 9'h030, 4'h0);
    drive(ZERO, 9'h000, 4'h1);
    drive(EN, 9'h000, 4'h1);
    steps(2, 1'h1, 1'h0, 4'h2);
    zc_rise();
    check(eventCapture[31:0], 32'h0000_0002);
    read(qepc_pkg::QEPC_READ_CAPTURE, d);
    check(d, 32'h0000_0002);
    @(posedge ref_clk) zeroOrCaptureInput <= 4'h0;
    drive(MODE, 9'h020, 4'h0);
    zc_rise();
    check(eventCount[31:0], 32'h0000_0000);
    @(posedge ref_clk) zeroOrCaptureInput <= 4'h0;
    drive(MODE, 9'h000, 4'h0);
    steps(1, 1'h1, 1'h0, 4'h2);
    zc_rise();
    check(eventCount[31:0], 32'h0000_0001);
    @(posedge ref_clk) zeroOrCaptureInput <= 4'h0;
    drive(EN, 9'h000, 4'h0);
    drive(MODE, 9'h0C0, 4'h0);
    drive(ZERO, 9'h000, 4'h1);
    drive(EN, 9'h000, 4'h1);
    steps(3, 1'h1, 1'h0, 4'h8);
    t = pwCount[31:0];
    check({31'h0, thirdRiseCapture[31:0] != 32'h0}, 32'h0000_0001);
    check({31'h0, newestRiseCapture[31:0] > thirdRiseCapture[31:0]},
          32'h0000_0001);
    drive(PWC, 9'h000, 4'h1);
    repeat (10) @(posedge ref_clk);
    #1;
    check({31'h0, pwCount[31:0] > t}, 32'h0000_0001);
    check({31'h0, pwSoftCapture[31:0] > t}, 32'h0000_0001);
    check({31'h0, newestFallCapture[31:0] > newestRiseCapture[31:0]},
          32'h0000_0001);
    // mid-run reset, held long enough to reach the reference domain
    @(posedge ref_clk) reset <= 1'h1;
    repeat (10) @(posedge ref_clk);
    reset <= 1'h0;
    #1;
    check(eventCapture[63:32], 32'h0000_0000);
    check(newestRiseCapture[31:0], 32'h0000_0000);
    results();
  end
endmodule
